// File: dv/eopc_assertions.sv
/*
 * Checker for the register and polarity behaviour of eopc_top.
 * Assumes it is bound to eopc_top and sees its ports only.
 */
`timescale 1ns/1ns
module eopc_checker (
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic       i_ext_rst_n,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_reg_rvalid,
    input wire logic [3:0] o_out_level
);
    // Two cycles of shadow after any reset so $past never spans it
    logic [1:0] rst_d;
    wire logic  in_rst = i_srst || !i_ext_rst_n;
    wire logic  pol_wr = i_reg_wr && (i_reg_addr == 8'h34);
    always_ff @(posedge i_clk) begin
        rst_d <= {rst_d[0], in_rst};
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (in_rst || (rst_d != 2'b00));
    sequence pol_wr_s;
        pol_wr;
    endsequence
    sequence pol_rd_s;
        i_reg_rd && !i_reg_wr && (i_reg_addr == 8'h34);
    endsequence
    rvalid_pulse_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe gave no valid pulse");
    rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("valid pulse without read");
    rdata_hold_a: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
        else $error("read data moved without read");
    pol_apply_a: assert property (pol_wr_s |-> ##2 {4'h0, o_out_level} == ($past(i_reg_wdata, 2) & 8'h0f))
        else $error("polarity write not applied");
    level_cause_a: assert property ($changed(o_out_level) |-> $past(pol_wr, 2))
        else $error("output level changed without polarity write");
    pol_readback_a: assert property (pol_wr_s ##2 pol_rd_s |=> o_reg_rdata == ($past(i_reg_wdata, 3) & 8'h0f))
        else $error("polarity readback wrong");
    unmapped_read_a: assert property (i_reg_rd && i_reg_addr == 8'hff |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    duty_reserved_a: assert property (i_reg_rd && i_reg_addr[7:2] == 6'h0c |=> o_reg_rdata[7:5] == 3'h0)
        else $error("duty reserved bits not zero");
endmodule

bind eopc_top eopc_checker chk (.i_clk, .i_srst, .i_ext_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_out_level);

// File: dv/eopc_bench.sv
/*
 * Self-checking bench for eopc_top with a host model on the register side.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ns
module eopc_bench;
    logic        i_clk       = 1'b0;
    logic        i_srst      = 1'b1;
    logic        i_ext_rst_n = 1'b1;
    logic [15:0] i_touch_raw = 16'h0000;
    wire logic   i_reg_wr, i_reg_rd, o_reg_rvalid, o_notify_n;
    wire logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
    wire logic [15:0] o_sense_channel_en, o_led_drive_oe;
    wire logic [3:0]  o_out_oe, o_out_level;
    logic [7:0]  rdat;
    logic        rv;
    logic [7:0]  d [4];
    logic [3:0]  pol, on;
    int          fail_count = 0;
    int          checks_done = 0;
    int          n;
    always #10 i_clk = ~i_clk;
    eopc_host host (.i_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
        .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    eopc_top uut (.i_clk, .i_srst, .i_ext_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .o_reg_rvalid, .i_touch_raw, .o_sense_channel_en, .o_led_drive_oe, .o_out_oe, .o_out_level, .o_notify_n);
    // ****************
    // Compare helpers
    // ****************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rdat, rv);
        chk({15'h0, rv}, 16'h1);
        chk({8'h0, rdat}, {8'h0, e});
    endtask
    // Open drain: a pin is driven only while its output is asserted; polarity picks the level
    function automatic logic [3:0] exp_oe(input logic [3:0] o);
        return o;
    endfunction
    // Samples at falling edges so no read races an update
    task automatic count(input int c, input int idx, output int k);
        k = 0;
        repeat (c) begin
            @(negedge i_clk);
            if (idx < 0) k += int'(!o_notify_n);
            else if (idx < 4) k += int'(o_out_oe[idx]);
            else k += int'(o_led_drive_oe[idx - 4]);
        end
        @(posedge i_clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h156a));
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        rdchk(8'h34, 8'h00);
        rdchk(8'h30, 8'h1f);
        rdchk(8'hff, 8'h00);
        // Dimming off: first pass has every duty zero
        for (int t = 0; t < 6; t++) begin
            pol = 4'($urandom);
            host.wr(8'h34, {4'($urandom), pol});
            rdchk(8'h34, {4'h0, pol});
            for (int i = 0; i < 4; i++) begin
                d[i] = (t == 0) ? 8'h00 : 8'($urandom_range(31));
                on[i] = (d[i] != 8'h00);
                host.wr(8'(8'h30 + i), d[i]);
            end
            repeat (4) @(posedge i_clk);
            @(negedge i_clk);
            chk(16'(o_out_level), 16'(pol));
            chk(16'(o_out_oe), 16'(exp_oe(on)));
            @(posedge i_clk);
        end
        host.wr(8'h06, 8'h20);
        host.wr(8'h34, 8'h0f);
        d = '{8'h1f, 8'h00, 8'($urandom_range(30, 1)), 8'h10};
        for (int i = 0; i < 4; i++) begin
            host.wr(8'(8'h30 + i), d[i]);
        end
        repeat (4) @(posedge i_clk);
        for (int i = 0; i < 4; i++) begin
            count(31, i, n);
            chk(16'(n), 16'(d[i]));
        end
        host.wr(8'h04, 8'h7f);
        host.wr(8'h0a, 8'h01);
        host.wr(8'h20, d[2]);
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        chk(o_sense_channel_en, 16'h7ffe);
        count(31, 4, n);
        chk(16'(n), 16'(d[2]));
        count(31, 5, n);
        chk(16'(n), 16'h0);
        @(posedge i_clk);
        i_touch_raw <= 16'h0001;
        count(6, -1, n);
        chk(16'(n), 16'h0);
        i_touch_raw <= 16'h0003;
        count(6, -1, n);
        chk(16'(n), 16'h1);
        host.wr(8'h34, 8'h0f);
        i_ext_rst_n <= 1'b0;
        @(posedge i_clk);
        i_ext_rst_n <= 1'b1;
        @(posedge i_clk);
        rdchk(8'h34, 8'h00);
        rdchk(8'h04, 8'hff);
        results;
    end
endmodule

// File: dv/eopc_host.sv
/*
 * Host model for the register side of eopc_top: one-cycle write and read strobes.
 * Assumes each task is entered just after a rising edge of i_clk.
 */
`timescale 1ns/1ns
module eopc_host (
    // Clock and read answer
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    // Strobes and bus
    output logic            o_wr    = 1'b0,
    output logic            o_rd    = 1'b0,
    output logic      [7:0] o_addr  = 8'h00,
    output logic      [7:0] o_wdata = 8'h00
);
    // ****************
    // Bus cycles
    // ****************
    // An idle edge follows each write, so two calls never set the strobe twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
        @(posedge i_clk);
    endtask

    // Answer is taken at the edge where the valid pulse is sampled high
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        @(posedge i_clk);
        v = i_rvalid;
        d = i_rdata;
    endtask
endmodule

// File: src/eopc_cfg.svh
/*
 * Offsets, field positions, reset values and counts for the exclusive output block.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef EOPC_CFG_SVH
`define EOPC_CFG_SVH

`define EOPC_ADDR_DIM_CTRL    8'h06
`define EOPC_DIM_EN_BIT       5
`define EOPC_ADDR_SENSE_EN_LO 8'h03
`define EOPC_ADDR_SENSE_EN_HI 8'h04
`define EOPC_ADDR_LED_SEL_LO  8'h0a
`define EOPC_ADDR_LED_SEL_HI  8'h0b
`define EOPC_ADDR_CH_DUTY0    8'h20
`define EOPC_ADDR_OUT_DUTY0   8'h30
`define EOPC_ADDR_POLARITY    8'h34
`define EOPC_ADDR_TOUCH_LO    8'h40
`define EOPC_ADDR_TOUCH_HI    8'h41
`define EOPC_RST_DUTY         5'h1f
`define EOPC_RST_POLARITY     4'h0
`define EOPC_RST_DIM_CTRL     8'h00
`define EOPC_RST_SENSE_EN     8'hff
`define EOPC_RST_LED_SEL      8'h00
`define EOPC_DUTY_MAX         5'h1f
`define EOPC_DUTY_ZERO        5'h00

`endif

// File: src/eopc_dimmer.sv
/*
 * One dimming output: 32-step duty compare against a shared phase counter.
 * Assumes phase counts 0..30 repeatedly, so duty 31 is always on.
 */
`timescale 1ns/1ns
`include "eopc_cfg.svh"
module eopc_dimmer
    import eopc_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Control
    input  wire eopc_duty_t i_duty,
    input  wire eopc_duty_t i_phase,
    input  wire logic       i_dim_en,
    // Asserted level
    output logic            o_on
);
    logic next_on;

    always_comb begin
        if (!i_dim_en) begin
            next_on = (i_duty != `EOPC_DUTY_ZERO);
        end else begin
            next_on = (i_phase < i_duty);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_on <= 1'b0;
        end else begin
            o_on <= next_on;
        end
    end
endmodule

// File: src/eopc_pkg.sv
/*
 * Types shared by the exclusive output block.
 * Assumes eopc_cfg.svh supplies all numeric constants.
 */
package eopc_pkg;
    typedef logic [4:0] eopc_duty_t;
    typedef logic [7:0] eopc_byte_t;
    typedef enum logic [1:0] {EOPC_IDLE, EOPC_NOTIFY} eopc_note_state_t;
endpackage

// File: src/eopc_top.sv
/*
 * Exclusive output block: register file reached by the host over the device's
 * serial bus front end (write strobe, address, data), four polarity-selected
 * dimmed outputs, sixteen shared sense/LED channels and the change notification.
 * Assumes the bus front end presents one-cycle strobes synchronous to i_clk and
 * that the touch engine presents its decisions synchronously.
 */
// Notes on behaviour
// - Register 0x34 bits 3..0 hold output polarities
// - Notify output drives low on touch change
// - Low reset pulse resets whole block
// - Host bus writes set dedicated output state
// - LED-assigned channel never reports touch
// - Thirty-two duty steps on dimmed channels
// - Duty 0x00 ground, 0x1f supply
// - Dimming disabled: nonzero duty means supply on the four outputs; the sixteen channels always dim
`timescale 1ns/1ns
`include "eopc_cfg.svh"
module eopc_top
    import eopc_pkg::*;
(
    // Clock and resets
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_ext_rst_n,
    // Register access from the serial bus front end
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_reg_rvalid,
    // Touch engine
    input  wire logic [15:0] i_touch_raw,
    output logic      [15:0] o_sense_channel_en,
    // Pins
    output logic      [15:0] o_led_drive_oe,
    output logic      [3:0]  o_out_oe,
    output logic      [3:0]  o_out_level,
    output logic             o_notify_n
);
    // ************************************************************
    // Register file
    // ************************************************************
    logic             rst;
    eopc_duty_t       out_duty   [4];
    eopc_duty_t       ch_duty    [16];
    logic [3:0]       polarity;
    eopc_byte_t       dim_ctrl;
    logic [15:0]      sense_en;
    logic [15:0]      led_sel;
    eopc_duty_t       next_out_duty [4];
    eopc_duty_t       next_ch_duty  [16];
    logic [3:0]       next_polarity;
    eopc_byte_t       next_dim_ctrl;
    logic [15:0]      next_sense_en;
    logic [15:0]      next_led_sel;

    // External pin is a low pulse; combined so either source resets everything
    assign rst = i_srst | ~i_ext_rst_n;

    always_comb begin
        next_polarity = polarity;
        next_dim_ctrl = dim_ctrl;
        next_sense_en = sense_en;
        next_led_sel  = led_sel;
        next_out_duty = out_duty;
        next_ch_duty  = ch_duty;
        if (i_reg_wr) begin
            for (int k = 0; k < 4; k++) begin
                if (i_reg_addr == `EOPC_ADDR_OUT_DUTY0 + 8'(k)) begin
                    next_out_duty[k] = i_reg_wdata[4:0];
                end
            end
            for (int k = 0; k < 16; k++) begin
                if (i_reg_addr == `EOPC_ADDR_CH_DUTY0 + 8'(k)) begin
                    next_ch_duty[k] = i_reg_wdata[4:0];
                end
            end
            unique case (i_reg_addr)
                `EOPC_ADDR_POLARITY:    next_polarity = i_reg_wdata[3:0];
                `EOPC_ADDR_DIM_CTRL:    next_dim_ctrl = i_reg_wdata;
                `EOPC_ADDR_SENSE_EN_LO: next_sense_en[7:0]  = i_reg_wdata;
                `EOPC_ADDR_SENSE_EN_HI: next_sense_en[15:8] = i_reg_wdata;
                `EOPC_ADDR_LED_SEL_LO:  next_led_sel[7:0]   = i_reg_wdata;
                `EOPC_ADDR_LED_SEL_HI:  next_led_sel[15:8]  = i_reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            polarity <= `EOPC_RST_POLARITY;
            dim_ctrl <= `EOPC_RST_DIM_CTRL;
            sense_en <= {2{`EOPC_RST_SENSE_EN}};
            led_sel  <= {2{`EOPC_RST_LED_SEL}};
            for (int k = 0; k < 4; k++) out_duty[k] <= `EOPC_RST_DUTY;
            for (int k = 0; k < 16; k++) ch_duty[k] <= `EOPC_RST_DUTY;
        end else begin
            polarity <= next_polarity;
            dim_ctrl <= next_dim_ctrl;
            sense_en <= next_sense_en;
            led_sel  <= next_led_sel;
            out_duty <= next_out_duty;
            ch_duty  <= next_ch_duty;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    eopc_byte_t next_rdata;
    logic [15:0] touch;

    always_comb begin
        next_rdata = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (i_reg_addr == `EOPC_ADDR_OUT_DUTY0 + 8'(k)) next_rdata = {3'h0, out_duty[k]};
        end
        for (int k = 0; k < 16; k++) begin
            if (i_reg_addr == `EOPC_ADDR_CH_DUTY0 + 8'(k)) next_rdata = {3'h0, ch_duty[k]};
        end
        unique case (i_reg_addr)
            `EOPC_ADDR_POLARITY:    next_rdata = {4'h0, polarity};
            `EOPC_ADDR_DIM_CTRL:    next_rdata = dim_ctrl;
            `EOPC_ADDR_SENSE_EN_LO: next_rdata = sense_en[7:0];
            `EOPC_ADDR_SENSE_EN_HI: next_rdata = sense_en[15:8];
            `EOPC_ADDR_LED_SEL_LO:  next_rdata = led_sel[7:0];
            `EOPC_ADDR_LED_SEL_HI:  next_rdata = led_sel[15:8];
            `EOPC_ADDR_TOUCH_LO:    next_rdata = touch[7:0];
            `EOPC_ADDR_TOUCH_HI:    next_rdata = touch[15:8];
            default: ;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rdata  <= i_reg_rd ? next_rdata : o_reg_rdata;
            o_reg_rvalid <= i_reg_rd;
        end
    end

    // ************************************************************
    // Dimming phase and outputs
    // ************************************************************
    eopc_duty_t phase;
    eopc_duty_t next_phase;
    logic [3:0] out_on;
    logic [15:0] ch_on;
    logic       dim_en;

    assign dim_en = dim_ctrl[`EOPC_DIM_EN_BIT];
    // Period of 31 steps keeps duty 0x1f fully on and 0x00 fully off
    assign next_phase = (phase == `EOPC_DUTY_MAX - 5'h01) ? 5'h00 : phase + 5'h01;

    always_ff @(posedge i_clk) begin
        if (rst) begin
            phase <= 5'h00;
        end else begin
            phase <= next_phase;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 20; g++) begin : g_dim
            logic on_bit;
            eopc_dimmer u_dim (
                .i_clk    (i_clk),
                .i_srst   (rst),
                .i_duty   (g < 4 ? out_duty[g % 4] : ch_duty[(g + 12) % 16]),
                .i_phase  (phase),
                .i_dim_en (g < 4 ? dim_en : 1'b1),
                .o_on     (on_bit)
            );
            if (g < 4) begin : g_out
                assign out_on[g] = on_bit;
            end else begin : g_ch
                assign ch_on[g - 4] = on_bit;
            end
        end
    endgenerate

    // ************************************************************
    // Pin drive, touch masking and change notification
    // ************************************************************
    logic [15:0] touch_prev;
    logic        next_notify_n;
    logic [3:0]  next_out_level;
    logic [3:0]  next_out_oe;
    logic [15:0] next_led_drive_oe;
    logic [15:0] next_sense_channel_en;
    logic [15:0] next_touch;

    // Open-drain outputs: the pin is driven only while the output is asserted,
    // polarity picks the driven level and the board pull resistor gives idle
    always_comb begin
        next_out_level        = polarity;
        next_out_oe           = out_on;
        next_led_drive_oe     = led_sel & ch_on;
        next_sense_channel_en = sense_en & ~led_sel;
        next_touch            = i_touch_raw & sense_en & ~led_sel;
        next_notify_n         = (touch == touch_prev);
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_out_level        <= 4'h0;
            o_out_oe           <= 4'h0;
            o_led_drive_oe     <= 16'h0000;
            o_sense_channel_en <= 16'h0000;
            touch              <= 16'h0000;
            touch_prev         <= 16'h0000;
            o_notify_n         <= 1'b1;
        end else begin
            o_out_level        <= next_out_level;
            o_out_oe           <= next_out_oe;
            o_led_drive_oe     <= next_led_drive_oe;
            o_sense_channel_en <= next_sense_channel_en;
            touch              <= next_touch;
            touch_prev         <= touch;
            o_notify_n         <= next_notify_n;
        end
    end
endmodule
